// ### hdl/spcr_serial_port.sv
// serial control port slave with its configuration registers
//
// Functional notes
// - soft reset bit resets whole device, starts eeprom load when enabled.
// - bit 6 set shifts lsb first, clear shifts msb first.
// - order, stepping and sdo enable do nothing in i2c mode.
// - bit 5 set increments address per byte, clear decrements.
// - bit 4 set drives sdo for 4-wire, clear keeps 3-wire.
// - low nibble mirrors high nibble reversed, effective value is their or.
// - both configuration registers never saved to eeprom.
// - readback select bit picks buffered or active copy.
// - keep-settings reset bit resets core, registers stay.
// - update bit copies buffered into active, then clears itself.
`include "spcr_params.svh"

module spcr_serial_port
    import spcr_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  sdio_in,
    output logic       sdio_out,
    output logic       sdio_oe_n,
    output logic       serial_out,
    output logic       serial_out_enable_n,
    input  wire logic  i2c_mode,
    input  wire logic  eeprom_en,
    input  spcr_addr_t save_query_addr,
    output logic       save_allowed,
    output logic       device_reset,
    output logic       eeprom_load,
    output logic       core_reset,
    output spcr_byte_t user_ctrl
);

    spcr_bus_if bus ();

    // =================================================================
    // pin synchronisers: first stage feeds only the second
    logic [2:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] sdio_sync_reg;
    logic [1:0] i2c_sync_reg;
    logic [1:0] eep_sync_reg;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_act;
    logic       din;
    logic       i2c_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg   <= 2'h3;
            sdio_sync_reg <= 2'h0;
            i2c_sync_reg  <= 2'h0;
            eep_sync_reg  <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
            cs_sync_reg   <= {cs_sync_reg[0], cs_n};
            sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
            i2c_sync_reg  <= {i2c_sync_reg[0], i2c_mode};
            eep_sync_reg  <= {eep_sync_reg[0], eeprom_en};
        end
    end

    // edges found on the second and third stages only
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign i2c_s     = i2c_sync_reg[1];
    assign cs_act    = ~cs_sync_reg[1] & ~i2c_s; // spi engine parked in i2c mode
    assign din       = sdio_sync_reg[1];

    // =================================================================
    // helpers
    function automatic spcr_addr_t step_addr(input spcr_addr_t a, input logic up);
        step_addr = up ? spcr_addr_t'(a + `SPCR_ADDR_STEP) : spcr_addr_t'(a - `SPCR_ADDR_STEP);
    endfunction

    // pick the byte bit due at a given position for the current order
    function automatic logic pick_bit(input spcr_byte_t b, input logic [3:0] n, input logic lsb);
        pick_bit = lsb ? b[n[2:0]] : b[3'h7 - n[2:0]];
    endfunction

    // =================================================================
    // shifter state
    spcr_state_e st_reg, st_next;
    logic [15:0] sh_reg, sh_next;
    logic [3:0]  cnt_reg, cnt_next;
    spcr_addr_t  addr_reg, addr_next;
    logic        rd_reg, rd_next;
    logic        wr_reg, wr_next;
    spcr_byte_t  wd_reg, wd_next;
    logic        dout_reg, dout_next;
    logic        sdio_oe_n_reg, sdio_oe_n_next;
    logic        sdo_oe_n_reg, sdo_oe_n_next;
    logic [15:0] sh_in;
    spcr_byte_t  rx_byte;

    // incoming bit lands at the end matching the bit order
    always_comb begin
        if (bus.lsb_first) begin
            sh_in = {din, sh_reg[15:1]};
        end else begin
            sh_in = {sh_reg[14:0], din};
        end
        rx_byte = bus.lsb_first ? sh_in[15:8] : sh_in[7:0];
    end

    // instruction is 16 bits: read flag then 15-bit address; then data bytes
    always_comb begin
        st_next        = st_reg;
        sh_next        = sh_reg;
        cnt_next       = cnt_reg;
        addr_next      = addr_reg;
        rd_next        = rd_reg;
        wr_next        = 1'b0;
        wd_next        = wd_reg;
        dout_next      = dout_reg;
        sdio_oe_n_next = sdio_oe_n_reg;
        sdo_oe_n_next  = sdo_oe_n_reg;
        case (st_reg)
            SPCR_IDLE: begin
                sdio_oe_n_next = 1'b1;
                sdo_oe_n_next  = 1'b1;
                cnt_next       = 4'h0;
                if (cs_act) begin
                    st_next = SPCR_INSTR;
                end
            end
            SPCR_INSTR: begin
                if (sclk_rise) begin
                    sh_next  = sh_in;
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `SPCR_INSTR_BITS) begin
                        st_next   = SPCR_DATA;
                        rd_next   = sh_in[`SPCR_RW_BIT];
                        addr_next = sh_in[14:0];
                        cnt_next  = 4'h0;
                    end
                end
            end
            SPCR_DATA: begin
                if (sclk_rise) begin
                    sh_next  = sh_in;
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `SPCR_BYTE_BITS) begin
                        cnt_next  = 4'h0;
                        wr_next   = ~rd_reg;
                        wd_next   = rx_byte;
                        addr_next = step_addr(addr_reg, bus.addr_ascend);
                    end
                end
                // reads drive on falling edge, sdo in 4-wire, sdio in 3-wire
                if (sclk_fall && rd_reg) begin
                    dout_next      = pick_bit(bus.rdata, cnt_reg, bus.lsb_first);
                    sdo_oe_n_next  = ~bus.sdo_enable;
                    sdio_oe_n_next = bus.sdo_enable;
                end
            end
            default: st_next = SPCR_IDLE;
        endcase
        if (!cs_act) begin
            st_next        = SPCR_IDLE;
            sdio_oe_n_next = 1'b1;
            sdo_oe_n_next  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg        <= SPCR_IDLE;
            sh_reg        <= 16'h0000;
            cnt_reg       <= 4'h0;
            addr_reg      <= 15'h0000;
            rd_reg        <= 1'b0;
            wr_reg        <= 1'b0;
            wd_reg        <= 8'h00;
            dout_reg      <= 1'b0;
            sdio_oe_n_reg <= 1'b1;
            sdo_oe_n_reg  <= 1'b1;
        end else begin
            st_reg        <= st_next;
            sh_reg        <= sh_next;
            cnt_reg       <= cnt_next;
            addr_reg      <= addr_next;
            rd_reg        <= rd_next;
            wr_reg        <= wr_next;
            wd_reg        <= wd_next;
            dout_reg      <= dout_next;
            sdio_oe_n_reg <= sdio_oe_n_next;
            sdo_oe_n_reg  <= sdo_oe_n_next;
        end
    end

    // =================================================================
    // write strobe carries the address of the byte just taken
    spcr_addr_t wr_addr_reg, wr_addr_next;

    always_comb begin
        wr_addr_next = wr_addr_reg;
        if (sclk_rise && st_reg == SPCR_DATA && cnt_reg == `SPCR_BYTE_BITS) begin
            wr_addr_next = addr_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr_reg <= 15'h0000;
        end else begin
            wr_addr_reg <= wr_addr_next;
        end
    end

    // bus address: write target during the strobe, else read pointer
    assign bus.wr_stb = wr_reg;
    assign bus.wdata  = wd_reg;
    assign bus.addr   = wr_reg ? wr_addr_reg : addr_reg;

    // =================================================================
    // register file
    spcr_regs u_regs (
        .clk             (clk),
        .rst_n           (rst_n),
        .i2c_mode        (i2c_s),
        .eeprom_en       (eep_sync_reg[1]),
        .bus             (bus.regs),
        .save_query_addr (save_query_addr),
        .device_reset    (device_reset),
        .eeprom_load     (eeprom_load),
        .core_reset      (core_reset),
        .save_allowed    (save_allowed),
        .user_ctrl       (user_ctrl)
    );

    // pins: both data outputs share one flop, enables pick the pin
    assign sdio_out            = dout_reg;
    assign serial_out          = dout_reg;
    assign sdio_oe_n           = sdio_oe_n_reg;
    assign serial_out_enable_n = sdo_oe_n_reg;

endmodule // spcr_serial_port

// ### hdl/spcr_params.svh
// constants for the serial port configuration block
`ifndef SPCR_PARAMS_SVH
`define SPCR_PARAMS_SVH

// =====================================================================
// register addresses
`define SPCR_ADDR_CFG_A      15'h0000
`define SPCR_ADDR_CFG_B      15'h0001
`define SPCR_ADDR_UPDATE     15'h000f
`define SPCR_ADDR_USER_CTRL  15'h0020

// =====================================================================
// field positions, configuration a
`define SPCR_A_SOFT_RST      7
`define SPCR_A_LSB_FIRST     6
`define SPCR_A_ADDR_ASC      5
`define SPCR_A_SDO_EN        4
`define SPCR_A_SDO_EN_M      3
`define SPCR_A_ADDR_ASC_M    2
`define SPCR_A_LSB_FIRST_M   1
`define SPCR_A_SOFT_RST_M    0

// field positions, configuration b and update
`define SPCR_B_READ_BUF      5
`define SPCR_B_RST_KEEP      2
`define SPCR_UPD_BIT         0

// =====================================================================
// reset values and masks
`define SPCR_CFG_A_DEF       8'h00
`define SPCR_CFG_B_DEF       8'h00
`define SPCR_CFG_B_MASK      8'h24
`define SPCR_USER_DEF        8'h00
`define SPCR_ZERO_BYTE       8'h00

// =====================================================================
// shifter framing
`define SPCR_INSTR_BITS      4'hf
`define SPCR_BYTE_BITS       4'h7
`define SPCR_RW_BIT          15
`define SPCR_ADDR_STEP       15'h0001

// =====================================================================
// internal reset pulse timing
`define SPCR_RST_HOLD_NS     1000
`define SPCR_CLK_MHZ         20
`define SPCR_RST_CYCLES      8'(((`SPCR_RST_HOLD_NS * `SPCR_CLK_MHZ) + 999) / 1000)
`define SPCR_CNT_ONE         8'h01
`define SPCR_CNT_ZERO        8'h00

`endif

// ### hdl/spcr_pkg.sv
// types shared by the serial port configuration block
package spcr_pkg;
    typedef logic [14:0] spcr_addr_t;
    typedef logic [7:0]  spcr_byte_t;
    typedef enum logic [1:0] {SPCR_IDLE, SPCR_INSTR, SPCR_DATA} spcr_state_e;
endpackage : spcr_pkg

// ### hdl/spcr_bus_if.sv
// register access and effective settings between shifter and register file
interface spcr_bus_if;
    import spcr_pkg::*;
    logic       wr_stb;
    spcr_addr_t addr;
    spcr_byte_t wdata;
    spcr_byte_t rdata;
    logic       lsb_first;
    logic       addr_ascend;
    logic       sdo_enable;

    modport port (output wr_stb, output addr, output wdata,
                  input rdata, input lsb_first, input addr_ascend, input sdo_enable);
    modport regs (input wr_stb, input addr, input wdata,
                  output rdata, output lsb_first, output addr_ascend, output sdo_enable);
endinterface : spcr_bus_if

// ### hdl/spcr_regs.sv
// configuration registers, buffered copy and internal reset sequencing
`include "spcr_params.svh"

module spcr_regs
    import spcr_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   i2c_mode,
    input  wire logic   eeprom_en,
    spcr_bus_if.regs    bus,
    input  spcr_addr_t  save_query_addr,
    output logic        device_reset,
    output logic        eeprom_load,
    output logic        core_reset,
    output logic        save_allowed,
    output spcr_byte_t  user_ctrl
);

    // =================================================================
    // state
    spcr_byte_t cfg_a_reg, cfg_a_next;
    spcr_byte_t cfg_b_reg, cfg_b_next;
    spcr_byte_t buf_reg, buf_next;
    spcr_byte_t act_reg, act_next;
    logic [7:0] cnt_reg, cnt_next;
    logic       full_reg, full_next;
    logic       load_reg, load_next;
    logic       save_reg, save_next;
    logic       dev_reg, dev_next;
    logic       core_reg, core_next;

    // nonvolatile save must skip the port configuration itself
    function automatic logic nv_savable(input spcr_addr_t a);
        nv_savable = (a != `SPCR_ADDR_CFG_A) && (a != `SPCR_ADDR_CFG_B);
    endfunction

    // =================================================================
    // effective settings: bit or its mirror; spi controls idle in i2c mode
    assign bus.lsb_first   = ~i2c_mode & (cfg_a_reg[`SPCR_A_LSB_FIRST] | cfg_a_reg[`SPCR_A_LSB_FIRST_M]);
    assign bus.addr_ascend = ~i2c_mode & (cfg_a_reg[`SPCR_A_ADDR_ASC] | cfg_a_reg[`SPCR_A_ADDR_ASC_M]);
    assign bus.sdo_enable  = ~i2c_mode & (cfg_a_reg[`SPCR_A_SDO_EN] | cfg_a_reg[`SPCR_A_SDO_EN_M]);

    // readback mux; buffered register source chosen by configuration b
    always_comb begin
        case (bus.addr)
            `SPCR_ADDR_CFG_A:     bus.rdata = cfg_a_reg;
            `SPCR_ADDR_CFG_B:     bus.rdata = cfg_b_reg;
            `SPCR_ADDR_USER_CTRL: bus.rdata = cfg_b_reg[`SPCR_B_READ_BUF] ? buf_reg : act_reg;
            default:              bus.rdata = `SPCR_ZERO_BYTE;
        endcase
    end

    // =================================================================
    // next state: writes are ignored while an internal reset runs
    always_comb begin
        cfg_a_next = cfg_a_reg;
        cfg_b_next = cfg_b_reg;
        buf_next   = buf_reg;
        act_next   = act_reg;
        cnt_next   = cnt_reg;
        full_next  = full_reg;
        load_next  = 1'b0;
        save_next  = nv_savable(save_query_addr);
        if (cnt_reg != `SPCR_CNT_ZERO) begin
            cnt_next = cnt_reg - `SPCR_CNT_ONE;
            if (cnt_reg == `SPCR_CNT_ONE) begin
                if (full_reg) begin
                    // whole-device reset returns every setting to default
                    cfg_a_next = `SPCR_CFG_A_DEF;
                    cfg_b_next = `SPCR_CFG_B_DEF;
                    buf_next   = `SPCR_USER_DEF;
                    act_next   = `SPCR_USER_DEF;
                    load_next  = eeprom_en;
                end else begin
                    cfg_b_next[`SPCR_B_RST_KEEP] = 1'b0;
                end
            end
        end else if (bus.wr_stb) begin
            case (bus.addr)
                `SPCR_ADDR_CFG_A: begin
                    cfg_a_next = bus.wdata;
                    if (bus.wdata[`SPCR_A_SOFT_RST] | bus.wdata[`SPCR_A_SOFT_RST_M]) begin
                        cnt_next  = `SPCR_RST_CYCLES;
                        full_next = 1'b1;
                    end
                end
                `SPCR_ADDR_CFG_B: begin
                    cfg_b_next = bus.wdata & `SPCR_CFG_B_MASK;
                    if (bus.wdata[`SPCR_B_RST_KEEP]) begin
                        cnt_next  = `SPCR_RST_CYCLES;
                        full_next = 1'b0;
                    end
                end
                `SPCR_ADDR_UPDATE: begin
                    // self-clearing: nothing is stored, so it always reads 0
                    if (bus.wdata[`SPCR_UPD_BIT]) begin
                        act_next = buf_reg;
                    end
                end
                `SPCR_ADDR_USER_CTRL: buf_next = bus.wdata;
                default: ;
            endcase
        end
        dev_next  = (cnt_next != `SPCR_CNT_ZERO) & full_next;
        core_next = (cnt_next != `SPCR_CNT_ZERO) & ~full_next;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_a_reg <= `SPCR_CFG_A_DEF;
            cfg_b_reg <= `SPCR_CFG_B_DEF;
            buf_reg   <= `SPCR_USER_DEF;
            act_reg   <= `SPCR_USER_DEF;
            cnt_reg   <= `SPCR_CNT_ZERO;
            full_reg  <= 1'b0;
            load_reg  <= 1'b0;
            save_reg  <= 1'b0;
            dev_reg   <= 1'b0;
            core_reg  <= 1'b0;
        end else begin
            cfg_a_reg <= cfg_a_next;
            cfg_b_reg <= cfg_b_next;
            buf_reg   <= buf_next;
            act_reg   <= act_next;
            cnt_reg   <= cnt_next;
            full_reg  <= full_next;
            load_reg  <= load_next;
            save_reg  <= save_next;
            dev_reg   <= dev_next;
            core_reg  <= core_next;
        end
    end

    assign device_reset = dev_reg;
    assign eeprom_load  = load_reg;
    assign core_reset   = core_reg;
    assign save_allowed = save_reg;
    assign user_ctrl    = act_reg;

endmodule // spcr_regs

// ### verification/spcr_host.sv
// behavioural spi host driving the serial control port
module spcr_host
    import spcr_pkg::*;
(
    output logic      sclk,
    output logic      cs_n,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe_n,
    input  wire logic serial_out,
    input  wire logic serial_out_enable_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       drv;
    spcr_byte_t got_q[$];

    // ==========================================================
    // wire level: device wins while enabled, else host value
    assign sdio_in = !sdio_oe_n ? sdio_out : drv;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv  = 1'b0;
    end

    // ==========================================================
    // one mode 0 frame: 400 ns sclk, data moves while sclk low
    task automatic xfer(input logic rw, input spcr_addr_t a, input int n, input logic [15:0] wd, input logic lsb);
        logic [15:0] w;
        spcr_byte_t  d;
        spcr_byte_t  r;
        logic        b;
        w = {rw, a};
        cs_n = 1'b0;
        #200;
        for (int i = 0; i < 16; i++) begin
            drv = lsb ? w[i] : w[15-i];
            #200;
            sclk = 1'b1;
            #200;
            sclk = 1'b0;
        end
        for (int k = 0; k < n; k++) begin
            d = (k == 0) ? wd[15:8] : wd[7:0];
            for (int i = 0; i < 8; i++) begin
                // released line toggles so a stale level never reads as data
                drv = rw ? ~drv : (lsb ? d[i] : d[7-i]);
                #200;
                sclk = 1'b1;
                #190;
                b = serial_out_enable_n ? sdio_in : serial_out;
                if (lsb) r[i] = b;
                else r[7-i] = b;
                #10;
                sclk = 1'b0;
            end
            if (rw) got_q.push_back(r);
        end
        #200;
        cs_n = 1'b1;
        #400;
    endtask
endmodule // spcr_host

// ### verification/spcr_monitor.sv
// port-level assertions for the serial port configuration block
module spcr_monitor
    import spcr_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       sdio_oe_n,
    input wire logic       serial_out_enable_n,
    input wire logic       i2c_mode,
    input wire spcr_addr_t save_query_addr,
    input wire logic       save_allowed,
    input wire logic       device_reset,
    input wire logic       eeprom_load,
    input wire logic       core_reset
);
    localparam int RST_LEN = 20;
    logic [7:0] dr_cnt_reg, dr_cnt_next, cr_cnt_reg, cr_cnt_next;
    logic       up_reg, up_next;

    // ==========================================================
    // pulse length counters; up masks the first edge after reset
    always_comb begin
        dr_cnt_next = device_reset ? dr_cnt_reg + 8'h01 : 8'h00;
        cr_cnt_next = core_reset ? cr_cnt_reg + 8'h01 : 8'h00;
        up_next     = 1'b1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dr_cnt_reg <= 8'h00;
            cr_cnt_reg <= 8'h00;
            up_reg     <= 1'b0;
        end else begin
            dr_cnt_reg <= dr_cnt_next;
            cr_cnt_reg <= cr_cnt_next;
            up_reg     <= up_next;
        end
    end

    // ==========================================================
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_cs_idle; cs_n [*6]; endsequence
    sequence s_i2c_held; i2c_mode [*6]; endsequence
    property p_save_query; up_reg |-> save_allowed == ($past(save_query_addr) > 15'h0001); endproperty
    property p_oe_excl; !(!sdio_oe_n && !serial_out_enable_n); endproperty
    property p_cs_idle; s_cs_idle |-> sdio_oe_n && serial_out_enable_n; endproperty
    property p_i2c_park; s_i2c_held |-> sdio_oe_n && serial_out_enable_n; endproperty
    property p_load_pulse; eeprom_load |=> !eeprom_load; endproperty
    property p_load_end; $rose(eeprom_load) |-> $past(device_reset) || $past(device_reset, 2); endproperty
    property p_dev_len; $fell(device_reset) |-> dr_cnt_reg == RST_LEN; endproperty
    property p_core_len; $fell(core_reset) |-> cr_cnt_reg == RST_LEN; endproperty
    property p_one_reset; !(device_reset && core_reset); endproperty
    a_save_query: assert property (p_save_query) else $error("save answer wrong");
    a_oe_excl: assert property (p_oe_excl) else $error("both outputs driven");
    a_cs_idle: assert property (p_cs_idle) else $error("driving while deselected");
    a_i2c_park: assert property (p_i2c_park) else $error("driving in i2c mode");
    a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
    a_load_end: assert property (p_load_end) else $error("load not at reset end");
    a_dev_len: assert property (p_dev_len) else $error("device reset length");
    a_core_len: assert property (p_core_len) else $error("core reset length");
    a_one_reset: assert property (p_one_reset) else $error("two resets at once");
endmodule // spcr_monitor

bind spcr_serial_port spcr_monitor i_mon (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sdio_oe_n(sdio_oe_n),
    .serial_out_enable_n(serial_out_enable_n), .i2c_mode(i2c_mode), .save_query_addr(save_query_addr),
    .save_allowed(save_allowed), .device_reset(device_reset), .eeprom_load(eeprom_load), .core_reset(core_reset));

// ### verification/serial_port_config_regs_bench.sv
// self-checking bench for the serial port configuration block
module serial_port_config_regs_bench;
    import spcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0, rst_n = 1'b0, i2c_mode = 1'b0, eeprom_en = 1'b0, lsb = 1'b0;
    spcr_addr_t save_query_addr = 15'h0000;
    logic       sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, serial_out, serial_out_enable_n;
    logic       save_allowed, device_reset, eeprom_load, core_reset;
    spcr_byte_t user_ctrl, r;
    spcr_byte_t exp_q[$];
    int         error_cnt = 0, check_count = 0, load_cnt = 0, seed = 32'he798;

    always #25 clk = ~clk;

    spcr_serial_port i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .serial_out(serial_out),
        .serial_out_enable_n(serial_out_enable_n), .i2c_mode(i2c_mode), .eeprom_en(eeprom_en),
        .save_query_addr(save_query_addr), .save_allowed(save_allowed), .device_reset(device_reset),
        .eeprom_load(eeprom_load), .core_reset(core_reset), .user_ctrl(user_ctrl));
    spcr_host i_host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .serial_out(serial_out), .serial_out_enable_n(serial_out_enable_n));

    // ==========================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input spcr_addr_t a, input int n, input logic [15:0] d);
        @(posedge clk);
        #2;
        i_host.xfer(1'b0, a, n, d, lsb);
    endtask
    // expectation noted before the frame, compared by the watcher
    task automatic rd(input spcr_addr_t a, input int n, input logic [15:0] e);
        exp_q.push_back(e[15:8]);
        if (n > 1) exp_q.push_back(e[7:0]);
        @(posedge clk);
        #2;
        i_host.xfer(1'b1, a, n, 16'h0000, lsb);
    endtask
    // bounded wait for any internal reset count to finish
    task automatic settle();
        for (int k = 0; k < 60 && (device_reset !== 1'b0 || core_reset !== 1'b0); k++) @(posedge clk);
        repeat (3) @(posedge clk);
        #2;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // watcher: every byte the host reads is matched to the oldest note
    initial begin
        forever begin
            wait (i_host.got_q.size() > 0);
            chk({8'h00, i_host.got_q.pop_front()}, {8'h00, exp_q.pop_front()});
        end
    end
    always @(posedge clk) if (eeprom_load === 1'b1) load_cnt++;

    // ==========================================================
    initial begin
        repeat (5) @(posedge clk);
        #2;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        chk(sdio_oe_n & serial_out_enable_n, 16'h0001);
        rd(15'h0000, 1, 16'h0000);
        rd(15'h0001, 1, 16'h0000);
        wr(15'h0000, 1, 16'h1800);
        rd(15'h0000, 1, 16'h1800);
        wr(15'h0001, 1, 16'hff00);
        chk(core_reset, 16'h0001);
        settle();
        rd(15'h0001, 1, 16'h2000);
        rd(15'h0000, 1, 16'h1800);
        r = 8'($random(seed)) | 8'h01;
        wr(15'h0020, 1, {r, 8'h00});
        rd(15'h0020, 1, {r, 8'h00});
        wr(15'h0001, 1, 16'h0000);
        rd(15'h0020, 1, 16'h0000);
        wr(15'h000f, 1, 16'h0100);
        chk(user_ctrl, r);
        rd(15'h0020, 1, {r, 8'h00});
        rd(15'h000f, 1, 16'h0000);
        // descending pair lands 0x0001 then 0x0000, ascending read back
        wr(15'h0001, 2, 16'h003c);
        rd(15'h0000, 2, 16'h3c00);
        wr(15'h0000, 1, 16'h0200);
        lsb = 1'b1;
        rd(15'h0000, 1, 16'h0200);
        i2c_mode = 1'b1;
        wr(15'h0000, 1, 16'h0000);
        i2c_mode = 1'b0;
        repeat (6) @(posedge clk);
        rd(15'h0000, 1, 16'h0200);
        eeprom_en = 1'b1;
        wr(15'h0000, 1, 16'h0100);
        chk(device_reset, 16'h0001);
        settle();
        lsb = 1'b0;
        chk(load_cnt, 16'h0001);
        rd(15'h0000, 1, 16'h0000);
        // direct order bit, then direct reset bit with no eeprom load
        eeprom_en = 1'b0;
        wr(15'h0000, 1, 16'h4000);
        lsb = 1'b1;
        rd(15'h0000, 1, 16'h4000);
        wr(15'h0000, 1, 16'h8000);
        chk(device_reset, 16'h0001);
        settle();
        lsb = 1'b0;
        chk(load_cnt, 16'h0001);
        rd(15'h0000, 1, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #2;
            save_query_addr = (i < 2) ? 15'(i) : 15'($random(seed));
            @(posedge clk);
            #2;
            chk(save_allowed, {15'h0000, save_query_addr > 15'h0001});
        end
        repeat (10) @(posedge clk);
        chk(exp_q.size(), 16'h0000);
        summarize();
    end

    // watchdog well past the roughly 300 us the sequence needs
    initial begin
        #2000000;
        error_cnt++;
        summarize();
    end
endmodule // serial_port_config_regs_bench
